// >>> sim/pheis_mgmt_master.sv
// Purpose: Management master model driving the register strobe port
// Assumes: One access per call, strobes raised at the falling edge
// Notes:   Released address and data lines show inverted values
`timescale 1ns/10ps
module pheis_mgmt_master (
  input  wire logic        mclk_i,
  output logic             rd_o,
  output logic             wr_o,
  output logic [4:0]       addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge mclk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Reads a register once and returns the answer word and its valid flag
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(negedge mclk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge mclk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    ok = rvalid_i;
  endtask
endmodule

// >>> sim/test_pheis_top.sv
// Purpose: Self-checking bench for the PHY event status block
// Assumes: Master model drives the register port
// Notes:   Inputs change at the falling clock edge
`timescale 1ns/10ps
module test_pheis_top;
  import pheis_pkg::*;
  logic        mclk_i = 1'b0;
  logic        srst_i, lnk, ld, rd, wr, rv, irq, ok;
  logic [7:0]  evt;
  logic [4:0]  ad;
  logic [15:0] wd, rdat, dd, v;
  int          fail_count, num_checks;
  pheis_top pheis_top_i (.mclk_i(mclk_i), .srst_i(srst_i), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .babble_evt_i(evt[7]), .rx_error_evt_i(evt[6]), .page_rx_evt_i(evt[5]), .pdf_evt_i(evt[4]),
    .partner_ack_evt_i(evt[3]), .link_ok_i(lnk & ~evt[2]), .remote_fault_evt_i(evt[1]),
    .autoneg_done_evt_i(evt[0]), .diag_load_i(ld), .diag_data_i(dd), .mac_raw_irq_status_o(irq));
  pheis_mgmt_master pheis_mgmt_master_i (.mclk_i(mclk_i), .rd_o(rd), .wr_o(wr), .addr_o(ad),
    .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic pulse(input int b);
    @(negedge mclk_i);
    evt[b] = 1'b1;
    @(negedge mclk_i);
    evt[b] = 1'b0;
  endtask
  task automatic rd11(output logic [15:0] d);
    pheis_mgmt_master_i.rd(PHEIS_ADDR_ICS, d, ok);
  endtask
  task automatic t_reset();
    rd11(v);
    chk(v, PHEIS_ICS_RESET);
    chk({15'h0000, ok}, 16'h0001);
    pheis_mgmt_master_i.rd(PHEIS_ADDR_DIAG, v, ok);
    chk(v, PHEIS_DIAG_RESET);
    pheis_mgmt_master_i.rd(5'h05, v, ok);
    chk(v, PHEIS_UNMAPPED);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_events();
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      repeat (3) @(negedge mclk_i);
      rd11(v);
      chk(v, 16'h0001 << i);
      rd11(v);
      chk(v, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
    end
  endtask
  task automatic t_enable();
    pheis_mgmt_master_i.wr(PHEIS_ADDR_ICS, 16'hFFFF);
    pheis_mgmt_master_i.wr(5'h13, 16'h0000);
    rd11(v);
    chk(v, 16'hFF00);
    for (int i = 0; i < 8; i++) begin
      pheis_mgmt_master_i.wr(PHEIS_ADDR_ICS, 16'h0100 << i);
      pulse((i + 1) % 8);
      @(negedge mclk_i);
      chk({15'h0000, irq}, 16'h0000);
      rd11(v);
      chk(v, (16'h0100 << i) | (16'h0001 << ((i + 1) % 8)));
      pulse(i);
      @(negedge mclk_i);
      chk({15'h0000, irq}, 16'h0001);
      rd11(v);
      chk(v, (16'h0100 << i) | (16'h0001 << i));
      @(negedge mclk_i);
      chk({15'h0000, irq}, 16'h0000);
    end
  endtask
  task automatic t_same();
    pheis_mgmt_master_i.wr(PHEIS_ADDR_ICS, 16'h0000);
    fork
      rd11(v);
      pulse(6);
    join
    chk(v, 16'h0000);
    rd11(v);
    chk(v, 16'h0040);
  endtask
  task automatic t_diag();
    @(negedge mclk_i);
    ld = 1'b1;
    dd = 16'hA5C3;
    @(negedge mclk_i);
    ld = 1'b0;
    dd = 16'h5A3C;
    @(negedge mclk_i);
    pheis_mgmt_master_i.wr(PHEIS_ADDR_DIAG, 16'h1234);
    pheis_mgmt_master_i.rd(PHEIS_ADDR_DIAG, v, ok);
    chk(v, 16'hA5C3);
    pheis_mgmt_master_i.wr(PHEIS_ADDR_ICS, 16'hFF00);
    @(negedge mclk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    srst_i = 1'b0;
    rd11(v);
    chk(v, PHEIS_ICS_RESET);
    pheis_mgmt_master_i.rd(PHEIS_ADDR_DIAG, v, ok);
    chk(v, PHEIS_DIAG_RESET);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    srst_i = 1'b1;
    lnk = 1'b0;
    ld = 1'b0;
    evt = 8'h00;
    dd = 16'h0000;
    repeat (6) @(negedge mclk_i);
    srst_i = 1'b0;
    lnk = 1'b1;
    t_reset();
    t_events();
    t_enable();
    t_same();
    t_diag();
    report_and_stop();
  end
endmodule

// >>> verilog/pheis_diag_mem.sv
// Purpose: Holds the auto-negotiation diagnostic word, registered read data
// Assumes: One word, loaded when a negotiation result is reported
// Notes:   Read data come out of a register
`timescale 1ns/10ps
module pheis_diag_mem
  import pheis_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] word_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      word_q <= PHEIS_DIAG_RESET;
    end else if (wr_i) begin
      word_q <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= PHEIS_DIAG_RESET;
    end else begin
      rdata_o <= word_q;
    end
  end
endmodule

// >>> verilog/pheis_pkg.sv
// Purpose: Constants for the PHY event interrupt control and status block
// Assumes: 16-bit management registers at 5-bit register addresses
// Notes:   Status bits sit in the low byte, enables in the high byte
package pheis_pkg;
  localparam int          PHEIS_NUM_EVT     = 8;
  localparam int          PHEIS_EN_SHIFT    = 8;
  localparam logic [4:0]  PHEIS_ADDR_ICS    = 5'h11;
  localparam logic [4:0]  PHEIS_ADDR_DIAG   = 5'h12;
  localparam logic [15:0] PHEIS_ICS_RESET   = 16'h0000;
  localparam logic [15:0] PHEIS_DIAG_RESET  = 16'h0000;
  localparam logic [15:0] PHEIS_UNMAPPED    = 16'h0000;
  localparam int          PHEIS_BIT_BABBLE  = 7;
  localparam int          PHEIS_BIT_RXERR   = 6;
  localparam int          PHEIS_BIT_PAGE    = 5;
  localparam int          PHEIS_BIT_PDF     = 4;
  localparam int          PHEIS_BIT_ACK     = 3;
  localparam int          PHEIS_BIT_LFAIL   = 2;
  localparam int          PHEIS_BIT_RFAULT  = 1;
  localparam int          PHEIS_BIT_ANDONE  = 0;
  localparam int          PHEIS_MEM_DEPTH   = 1;
  typedef enum logic [1:0] {PHEIS_RD_IDLE, PHEIS_RD_BUSY} pheis_rd_e;
endpackage

// >>> verilog/pheis_top.sv
// Purpose: PHY event interrupt control/status and diagnostic registers
// Assumes: Event inputs are one-cycle pulses or levels synchronous to mclk_i
// Notes:   Register port is a simple read/write strobe port with 5-bit address
`timescale 1ns/10ps
module pheis_top
  import pheis_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        babble_evt_i,
  input  wire logic        rx_error_evt_i,
  input  wire logic        page_rx_evt_i,
  input  wire logic        pdf_evt_i,
  input  wire logic        partner_ack_evt_i,
  input  wire logic        link_ok_i,
  input  wire logic        remote_fault_evt_i,
  input  wire logic        autoneg_done_evt_i,
  input  wire logic        diag_load_i,
  input  wire logic [15:0] diag_data_i,
  output logic             mac_raw_irq_status_o
);
  logic [7:0]  enable_q;
  logic [7:0]  flag_q;
  logic [7:0]  evt_set;
  logic        link_ok_q;
  logic        link_fail_evt;
  logic [15:0] diag_rdata;
  logic        ics_rd;

  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] b);
    addr_hit = (a == b);
  endfunction

  // Link status history for the good-to-failed edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      link_ok_q <= 1'b0;
    end else begin
      link_ok_q <= link_ok_i;
    end
  end

  assign link_fail_evt = link_ok_q & ~link_ok_i;

  always_comb begin
    evt_set                   = 8'h00;
    evt_set[PHEIS_BIT_BABBLE] = babble_evt_i;
    evt_set[PHEIS_BIT_RXERR]  = rx_error_evt_i;
    evt_set[PHEIS_BIT_PAGE]   = page_rx_evt_i;
    evt_set[PHEIS_BIT_PDF]    = pdf_evt_i;
    evt_set[PHEIS_BIT_ACK]    = partner_ack_evt_i;
    evt_set[PHEIS_BIT_LFAIL]  = link_fail_evt;
    evt_set[PHEIS_BIT_RFAULT] = remote_fault_evt_i;
    evt_set[PHEIS_BIT_ANDONE] = autoneg_done_evt_i;
  end

  assign ics_rd = reg_rd_i & addr_hit(reg_addr_i, PHEIS_ADDR_ICS);

  // Enable byte, written through the high byte of the control/status word
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      enable_q <= PHEIS_ICS_RESET[15:8];
    end else if (reg_wr_i && addr_hit(reg_addr_i, PHEIS_ADDR_ICS)) begin
      enable_q <= reg_wdata_i[15:8];
    end
  end

  // Sticky flags: read clears, a new event wins over the clear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flag_q <= PHEIS_ICS_RESET[7:0];
    end else if (ics_rd) begin
      flag_q <= evt_set;
    end else begin
      flag_q <= flag_q | evt_set;
    end
  end

  // Interrupt toward the MAC raw status
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mac_raw_irq_status_o <= 1'b0;
    end else begin
      mac_raw_irq_status_o <= |(flag_q & enable_q);
    end
  end

  pheis_diag_mem u_diag (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .wr_i    (diag_load_i),
    .wdata_i (diag_data_i),
    .rdata_o (diag_rdata)
  );

  // Read word returns one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (addr_hit(reg_addr_i, PHEIS_ADDR_ICS)) begin
          reg_rdata_o <= {enable_q, flag_q};
        end else if (addr_hit(reg_addr_i, PHEIS_ADDR_DIAG)) begin
          reg_rdata_o <= diag_rdata;
        end else begin
          reg_rdata_o <= PHEIS_UNMAPPED;
        end
      end
    end
  end

  // Assertions
  property p_irq_gate;
    @(posedge mclk_i) disable iff (srst_i)
      1'b1 |=> mac_raw_irq_status_o == |($past(flag_q) & $past(enable_q));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq not gated flags");

  property p_irq_raise;
    @(posedge mclk_i) disable iff (srst_i)
      (|(flag_q & enable_q)) |=> mac_raw_irq_status_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled flag did not raise irq");

  property p_blocked;
    @(posedge mclk_i) disable iff (srst_i)
      (enable_q == 8'h00) |=> !mac_raw_irq_status_o;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("irq with all enables clear");
  property p_babble_set;
    @(posedge mclk_i) disable iff (srst_i) babble_evt_i |=> flag_q[PHEIS_BIT_BABBLE];
  endproperty
  a_babble_set: assert property (p_babble_set)
    else $error("babble flag not set");
  property p_rxerr_set;
    @(posedge mclk_i) disable iff (srst_i) rx_error_evt_i |=> flag_q[PHEIS_BIT_RXERR];
  endproperty
  a_rxerr_set: assert property (p_rxerr_set)
    else $error("receive error flag not set");
  property p_lfail_set;
    @(posedge mclk_i) disable iff (srst_i) $fell(link_ok_i) && !$past(srst_i) |=> flag_q[PHEIS_BIT_LFAIL];
  endproperty
  a_lfail_set: assert property (p_lfail_set)
    else $error("link fail flag not set");
  property p_lfail_only;
    @(posedge mclk_i) disable iff (srst_i)
      (!flag_q[PHEIS_BIT_LFAIL] && !(link_ok_q && !link_ok_i)) |=> !flag_q[PHEIS_BIT_LFAIL];
  endproperty
  a_lfail_only: assert property (p_lfail_only)
    else $error("link fail flag without falling link");
  property p_rd_clear;
    @(posedge mclk_i) disable iff (srst_i) (ics_rd && evt_set == 8'h00) |=> flag_q == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read did not clear flags");
  property p_sticky;
    @(posedge mclk_i) disable iff (srst_i) (flag_q[0] && !ics_rd) |=> flag_q[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag lost without read");
  property p_rd_data;
    @(posedge mclk_i) disable iff (srst_i) ics_rd |=> reg_rvalid_o && reg_rdata_o == {$past(enable_q), $past(flag_q)};
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("control/status read data wrong");
  property p_reset;
    @(posedge mclk_i) srst_i |=> (enable_q == 8'h00 && flag_q == 8'h00);
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear register");

  property p_page_set;
    @(posedge mclk_i) disable iff (srst_i) page_rx_evt_i |=> flag_q[PHEIS_BIT_PAGE];
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("page flag not set");

  property p_pdf_set;
    @(posedge mclk_i) disable iff (srst_i) pdf_evt_i |=> flag_q[PHEIS_BIT_PDF];
  endproperty
  a_pdf_set: assert property (p_pdf_set)
    else $error("parallel detect fault flag not set");

  property p_ack_set;
    @(posedge mclk_i) disable iff (srst_i) partner_ack_evt_i |=> flag_q[PHEIS_BIT_ACK];
  endproperty
  a_ack_set: assert property (p_ack_set)
    else $error("partner acknowledge flag not set");

  property p_rfault_set;
    @(posedge mclk_i) disable iff (srst_i) remote_fault_evt_i |=> flag_q[PHEIS_BIT_RFAULT];
  endproperty
  a_rfault_set: assert property (p_rfault_set)
    else $error("remote fault flag not set");

  property p_andone_set;
    @(posedge mclk_i) disable iff (srst_i) autoneg_done_evt_i |=> flag_q[PHEIS_BIT_ANDONE];
  endproperty
  a_andone_set: assert property (p_andone_set)
    else $error("negotiation done flag not set");

  property p_flag_cause;
    @(posedge mclk_i) disable iff (srst_i)
      1'b1 |=> (flag_q & ~$past(flag_q) & ~$past(evt_set)) == 8'h00;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag rose without its event");

  property p_rd_keep;
    @(posedge mclk_i) disable iff (srst_i) ics_rd |=> flag_q == $past(evt_set);
  endproperty
  a_rd_keep: assert property (p_rd_keep)
    else $error("event lost in clearing read");

  property p_sticky_all;
    @(posedge mclk_i) disable iff (srst_i) !ics_rd |=> (flag_q & $past(flag_q)) == $past(flag_q);
  endproperty
  a_sticky_all: assert property (p_sticky_all)
    else $error("a flag dropped without read");

  property p_en_write;
    @(posedge mclk_i) disable iff (srst_i)
      (reg_wr_i && addr_hit(reg_addr_i, PHEIS_ADDR_ICS)) |=> {enable_q, 8'h00} == ($past(reg_wdata_i) & 16'hFF00);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable byte not written");

  property p_en_hold;
    @(posedge mclk_i) disable iff (srst_i)
      !(reg_wr_i && addr_hit(reg_addr_i, PHEIS_ADDR_ICS)) |=> $stable(enable_q);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enable byte changed without write");

  property p_rvalid;
    @(posedge mclk_i) disable iff (srst_i) reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read not answered");

  property p_rvalid_quiet;
    @(posedge mclk_i) disable iff (srst_i) !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rvalid_quiet: assert property (p_rvalid_quiet)
    else $error("read valid without read");

  property p_rdata_hold;
    @(posedge mclk_i) disable iff (srst_i) !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without read");

  property p_diag_rd;
    @(posedge mclk_i) disable iff (srst_i)
      (reg_rd_i && addr_hit(reg_addr_i, PHEIS_ADDR_DIAG)) |=> reg_rdata_o == $past(diag_rdata);
  endproperty
  a_diag_rd: assert property (p_diag_rd)
    else $error("diagnostic read data wrong");

  property p_unmapped;
    @(posedge mclk_i) disable iff (srst_i)
      (reg_rd_i && !addr_hit(reg_addr_i, PHEIS_ADDR_ICS) && !addr_hit(reg_addr_i, PHEIS_ADDR_DIAG))
      |=> reg_rdata_o == PHEIS_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_diag_load;
    @(posedge mclk_i) disable iff (srst_i) diag_load_i |=> ##1 diag_rdata == $past(diag_data_i, 2);
  endproperty
  a_diag_load: assert property (p_diag_load)
    else $error("diagnostic word not loaded");

  property p_reset_out;
    @(posedge mclk_i)
      srst_i |=> !mac_raw_irq_status_o && !reg_rvalid_o && reg_rdata_o == 16'h0000;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("reset did not clear outputs");

  property p_irq_read_off;
    @(posedge mclk_i) disable iff (srst_i) (ics_rd && evt_set == 8'h00) |=> ##1 !mac_raw_irq_status_o;
  endproperty
  a_irq_read_off: assert property (p_irq_read_off)
    else $error("irq stayed after clearing read");

  c_irq: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(mac_raw_irq_status_o));
  c_rd_evt: cover property (@(posedge mclk_i) disable iff (srst_i) ics_rd && evt_set != 8'h00);
  c_diag_rd: cover property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && addr_hit(reg_addr_i, PHEIS_ADDR_DIAG));
  c_lfail: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(flag_q[PHEIS_BIT_LFAIL]));
  c_diag_load: cover property (@(posedge mclk_i) disable iff (srst_i) diag_load_i);
endmodule
